//--- core/vmr_pkg.sv
// Purpose : Constants for the voltage monitor register block
// Assumes : 25 MHz clock, 16-bit register port
// Notes   : Periods in ms, counts derived from the clock rate
package vmr_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned CYC_PER_US        = CLK_HZ / 1_000_000;

  // Register addresses
  localparam logic [5:0]  ADDR_RESULT       = 6'h11;
  localparam logic [5:0]  ADDR_CONTROL      = 6'h12;
  localparam logic [5:0]  ADDR_RATE         = 6'h20;

  // Control register fields
  localparam int unsigned CTL_LOWRATE_MSB   = 4;
  localparam int unsigned CTL_ATTN_BIT      = 5;
  localparam int unsigned CTL_EN0_BIT       = 6;
  localparam int unsigned CTL_EN_MSB        = 10;
  localparam logic [15:0] CTL_RESET         = 16'h001F;
  localparam logic [4:0]  CTL_LOWRATE_VAL   = 5'h1F;

  // Result register fields
  localparam int unsigned RES_DATA_LSB      = 7;
  localparam int unsigned RES_IDX_LSB       = 2;

  // Rate register
  localparam logic [1:0]  RATE_RESET        = 2'h2;

  // Sensors
  localparam int unsigned NUM_SENSORS       = 5;
  localparam logic [2:0]  IDX_2V5           = 3'h0;
  localparam logic [2:0]  IDX_1V2           = 3'h1;
  localparam logic [2:0]  IDX_STANDBY       = 3'h2;
  localparam logic [2:0]  IDX_5V            = 3'h3;
  localparam logic [2:0]  IDX_12V           = 3'h4;
  localparam logic [8:0]  CODE_NOMINAL      = 9'h180;
  localparam logic [8:0]  CODE_MAX          = 9'h1FF;
  localparam logic [8:0]  CODE_MIN          = 9'h000;
  localparam logic [8:0]  CODE_STANDBY_MIN  = 9'h15D;

  // Conversion times, in microseconds
  localparam int unsigned TEMP_CONV_US      = 7500;
  localparam int unsigned VOLT_CONV_US      = 1420;
  localparam int unsigned TEMP_CONVS        = 3;
  localparam int unsigned TEMP_PHASE_CYC    = TEMP_CONVS * TEMP_CONV_US * CYC_PER_US;
  localparam int unsigned VOLT_CONV_CYC     = VOLT_CONV_US * CYC_PER_US;

  // Conversion periods, in milliseconds
  localparam int unsigned PERIOD_91_MS      = 91;
  localparam int unsigned PERIOD_182_MS     = 182;
  localparam int unsigned PERIOD_364_MS     = 364;
  localparam int unsigned PERIOD_728_MS     = 728;
  localparam int unsigned PERIOD_1456_MS    = 1456;
  localparam int unsigned CYC_PER_MS        = CLK_HZ / 1000;
  localparam int unsigned MS_TICK_CYC       = CYC_PER_MS;

  // Saturate the converter reading to the 9-bit code range
  function automatic logic [8:0] vmr_saturate(input logic [9:0] raw);
    vmr_saturate = raw[9] ? CODE_MAX : raw[8:0];
  endfunction

endpackage

//--- core/vmr_result_if.sv
// Purpose : Carries a finished conversion from the sequencer to the register file
// Assumes : One clock domain
// Notes   : store is a one-cycle pulse with index and code valid alongside
`timescale 1ns/1ps
interface vmr_result_if;
  logic       store;
  logic [2:0] index;
  logic [8:0] code;
  logic [3:0] period_sel;
  logic       busy;

  modport seq (output store, output index, output code, output busy, input period_sel);
  modport regs (input store, input index, input code, input busy, output period_sel);
endinterface

//--- core/vmr_sequencer.sv
// Purpose : Scans enabled voltage sensors and paces conversions
// Assumes : Analog reading per sensor arrives as a 10-bit raw value
// Notes   : Temperature slots only consume time here
`timescale 1ns/1ps
module vmr_sequencer
  import vmr_pkg::*;
#(
  parameter int unsigned TEMP_CYC  = TEMP_PHASE_CYC,
  parameter int unsigned VOLT_CYC  = VOLT_CONV_CYC,
  parameter int unsigned MS_CYC    = MS_TICK_CYC
)(
  input  wire logic                       mclk_i,
  input  wire logic                       rstn_i,
  input  wire logic [NUM_SENSORS-1:0]     enables_i,
  input  wire logic [NUM_SENSORS*10-1:0]  raw_i,
  vmr_result_if.seq                       res
);

  typedef enum logic [1:0] {VMR_IDLE, VMR_TEMP, VMR_VOLT, VMR_WAIT} vmr_state_t;

  vmr_state_t  state_reg;
  vmr_state_t  state_next;
  logic [31:0] cnt_reg;
  logic [31:0] ms_cnt_reg;
  logic [11:0] ms_reg;
  logic [2:0]  idx_reg;
  logic [2:0]  idx_next;
  logic        any_en;
  logic        ms_tick;
  logic        cnt_done;
  logic        last_volt;
  logic [11:0] period_ms;
  logic [9:0]  raw_sel;

  // Period lookup from low-power bit and rate select
  // period table
  always_comb
  begin
    unique case (res.period_sel)
      4'h0:    period_ms = 12'h000;
      4'h1:    period_ms = 12'(PERIOD_91_MS);
      4'h2:    period_ms = 12'(PERIOD_182_MS);
      4'h3:    period_ms = 12'(PERIOD_364_MS);
      4'h4:    period_ms = 12'(PERIOD_91_MS);
      4'h5:    period_ms = 12'(PERIOD_364_MS);
      4'h6:    period_ms = 12'(PERIOD_728_MS);
      default: period_ms = 12'(PERIOD_1456_MS);
    endcase
  end

  // Next enabled sensor above the current one, wrapping
  // round-robin skip
  always_comb
  begin
    idx_next = idx_reg;
    for (int k = NUM_SENSORS; k >= 1; k--)
    begin
      if (enables_i[(int'(idx_reg) + k) % NUM_SENSORS])
        idx_next = 3'((int'(idx_reg) + k) % NUM_SENSORS);
    end
  end

  assign any_en    = |enables_i;
  assign ms_tick   = (ms_cnt_reg == MS_CYC - 1);
  assign raw_sel   = raw_i[idx_reg*10 +: 10];
  assign last_volt = (idx_next <= idx_reg);

  // Phase sequencing: temperatures, voltages, then idle to the period
  // cycle composition
  always_comb
  begin
    state_next = state_reg;
    cnt_done   = 1'b0;
    unique case (state_reg)
      VMR_IDLE: if (any_en) state_next = VMR_TEMP;
      VMR_TEMP:
      begin
        cnt_done = (cnt_reg == TEMP_CYC - 1);
        if (cnt_done) state_next = VMR_VOLT;
      end
      VMR_VOLT:
      begin
        cnt_done = (cnt_reg == VOLT_CYC - 1);
        if (cnt_done && (last_volt || !any_en)) state_next = VMR_WAIT;
      end
      VMR_WAIT: if (ms_reg >= period_ms) state_next = VMR_IDLE;
    endcase
  end

  // Counters and sensor pointer
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      state_reg  <= VMR_IDLE;
      cnt_reg    <= '0;
      ms_cnt_reg <= '0;
      ms_reg     <= '0;
      idx_reg    <= '0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= (cnt_done || state_next != state_reg) ? '0 : cnt_reg + 32'h1;
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 32'h1;
      if (state_reg == VMR_IDLE && any_en)
        ms_reg <= '0;
      else if (ms_tick && ms_reg != 12'hFFF)
        ms_reg <= ms_reg + 12'h1;
      if (state_reg == VMR_TEMP && cnt_done && !enables_i[idx_reg])
        idx_reg <= idx_next;
      else if (state_reg == VMR_VOLT && cnt_done)
        idx_reg <= idx_next;
    end
  end

  // Result hand-off, one pulse per finished enabled sensor
  // enabled only
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      res.store <= 1'b0;
      res.index <= '0;
      res.code  <= '0;
      res.busy  <= 1'b0;
    end
    else
    begin
      res.store <= (state_reg == VMR_VOLT) && cnt_done && enables_i[idx_reg];
      res.index <= idx_reg;
      res.code  <= vmr_saturate(raw_sel);
      res.busy  <= (state_reg != VMR_IDLE);
    end
  end

endmodule // vmr_sequencer

//--- core/vmr_regs.sv
// Purpose : Register file of the voltage measurement function
// Assumes : Bus framing decoded outside; one access strobe per cycle
// Notes   : Reads return data one cycle after the strobe
//
// Function
// - 9-bit result left aligned, zero bits
// - Index field shows result's sensor
// - Index codes 0..4 per input
// - Unsigned codes, saturating at ends
// - Control resets to 1Fh
// - Low-rate field read-only, top zero
// - Attention needs enable and sensor enable
// - Measure only enabled sensors
// - Rate select resets 2h, rewritable
// - Period table from select, low power
// - Continuous cycle: temps then voltages
// - Period uses low-power bit too
// - Ascending round-robin, skip disabled
// - Store sets status, overrun; read clears
// - New result raises event, gated attention
`timescale 1ns/1ps
module vmr_regs
  import vmr_pkg::*;
#(
  parameter int unsigned TEMP_CYC  = TEMP_PHASE_CYC,
  parameter int unsigned VOLT_CYC  = VOLT_CONV_CYC,
  parameter int unsigned MS_CYC    = MS_TICK_CYC
)(
  input  wire logic                       mclk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       reg_rd_i,
  input  wire logic                       reg_wr_i,
  input  wire logic [5:0]                 reg_addr_i,
  input  wire logic [15:0]                reg_wdata_i,
  input  wire logic                       low_power_select_i,
  input  wire logic [NUM_SENSORS*10-1:0]  raw_i,
  output logic      [15:0]                reg_rdata_o,
  output logic                            reg_rvalid_o,
  output logic                            voltage_status_flag_o,
  output logic                            voltage_overrun_flag_o,
  output logic                            function_event_o,
  output logic                            attention_o,
  output logic                            conv_busy_o
);

  vmr_result_if res ();

  logic [8:0]  result_code_reg;
  logic [2:0]  sensor_index_reg;
  logic        attn_en_reg;
  logic        sensor0_enable_reg;
  logic [3:0]  sensor_enables_upper_reg;
  logic [1:0]  rate_select_reg;
  logic        status_reg;
  logic        overrun_reg;
  logic [15:0] result_word;
  logic [15:0] control_word;
  logic [15:0] rate_word;
  logic [15:0] rdata_next;
  logic        hit_result;
  logic        hit_control;
  logic        hit_rate;
  logic        rd_result;
  logic        wr_control;
  logic        wr_rate;
  logic [NUM_SENSORS-1:0] enables;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  vmr_sequencer #(
    .TEMP_CYC (TEMP_CYC),
    .VOLT_CYC (VOLT_CYC),
    .MS_CYC   (MS_CYC)
  ) u_seq (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .enables_i (enables),
    .raw_i     (raw_i),
    .res       (res.seq)
  );

  // Enables and period selection toward the sequencer
  // low-power joins select
  assign enables        = {sensor_enables_upper_reg, sensor0_enable_reg};
  assign res.period_sel = {1'b0, low_power_select_i, rate_select_reg};

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  assign hit_result  = (reg_addr_i == ADDR_RESULT);
  assign hit_control = (reg_addr_i == ADDR_CONTROL);
  assign hit_rate    = (reg_addr_i == ADDR_RATE);
  assign rd_result   = reg_rd_i && hit_result;
  assign wr_control  = reg_wr_i && hit_control;
  assign wr_rate     = reg_wr_i && hit_rate;

  // Read words with reserved bits forced to zero
  // left aligned result
  assign result_word  = {result_code_reg, 2'b00, sensor_index_reg, 2'b00};
  assign control_word = {5'h00, sensor_enables_upper_reg, sensor0_enable_reg, attn_en_reg, CTL_LOWRATE_VAL};
  assign rate_word    = {14'h0000, rate_select_reg};
  assign rdata_next   = hit_result  ? result_word  :
                        hit_control ? control_word :
                        hit_rate    ? rate_word    : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Readout register

  // Index and code captured in the same edge
  // consistent pair
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      result_code_reg  <= CODE_MIN;
      sensor_index_reg <= IDX_2V5;
    end
    else if (res.store)
    begin
      result_code_reg  <= res.code;
      sensor_index_reg <= res.index;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and rate registers

  // Writes touch only the writable fields
  // reset value
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      attn_en_reg              <= CTL_RESET[CTL_ATTN_BIT];
      sensor0_enable_reg       <= CTL_RESET[CTL_EN0_BIT];
      sensor_enables_upper_reg <= CTL_RESET[CTL_EN_MSB:CTL_EN0_BIT+1];
    end
    else if (wr_control)
    begin
      attn_en_reg              <= reg_wdata_i[CTL_ATTN_BIT];
      sensor0_enable_reg       <= reg_wdata_i[CTL_EN0_BIT];
      sensor_enables_upper_reg <= reg_wdata_i[CTL_EN_MSB:CTL_EN0_BIT+1];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      rate_select_reg <= RATE_RESET;
    else if (wr_rate)
      rate_select_reg <= reg_wdata_i[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Status, overrun and events

  // Store beats a simultaneous clearing read for status; the read wins for overrun
  // set and clear
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      status_reg  <= 1'b0;
      overrun_reg <= 1'b0;
    end
    else
    begin
      status_reg  <= res.store | (status_reg & ~rd_result);
      overrun_reg <= (res.store & status_reg & ~rd_result) | (overrun_reg & ~rd_result);
    end
  end

  // Event pulse and gated attention request
  // event per store
  // attention gating
  // Pulse pace follows the scan
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      function_event_o <= 1'b0;
      attention_o      <= 1'b0;
    end
    else
    begin
      function_event_o <= res.store;
      attention_o      <= res.store & attn_en_reg & (|enables);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      reg_rdata_o            <= 16'h0000;
      reg_rvalid_o           <= 1'b0;
      voltage_status_flag_o  <= 1'b0;
      voltage_overrun_flag_o <= 1'b0;
      conv_busy_o            <= 1'b0;
    end
    else
    begin
      reg_rdata_o            <= reg_rd_i ? rdata_next : 16'h0000;
      reg_rvalid_o           <= reg_rd_i;
      voltage_status_flag_o  <= status_reg;
      voltage_overrun_flag_o <= overrun_reg;
      conv_busy_o            <= res.busy;
    end
  end

endmodule // vmr_regs

//--- testbench/vmr_regs_asserts.sv
// Purpose : Port checks for the voltage register block
// Assumes : One clock, synchronous active-low reset
// Notes   : Control value is shadowed from bus writes
`timescale 1ns/1ps
module vmr_regs_asserts
  import vmr_pkg::*;
#(
  parameter int unsigned TEMP_CYC = 20,
  parameter int unsigned VOLT_CYC = 10,
  parameter int unsigned MS_CYC   = 5
)(
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [5:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        voltage_status_flag_o,
  input wire logic        voltage_overrun_flag_o,
  input wire logic        function_event_o,
  input wire logic        attention_o
);
////////////////////////////////////////
  logic [15:0] ctl_reg;
  logic [3:0]  noen_reg;
  // Decoded views of the shadow and of the bus read
  wire logic   en_any = |ctl_reg[CTL_EN_MSB:CTL_EN0_BIT];
  wire logic   att_ok = ctl_reg[CTL_ATTN_BIT] && en_any;
  wire logic   rd_res = reg_rd_i && reg_addr_i == ADDR_RESULT;
  // Control shadow and idle counter
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      ctl_reg <= CTL_RESET;
    else if (reg_wr_i && reg_addr_i == ADDR_CONTROL)
      ctl_reg <= reg_wdata_i;
    if (!rstn_i || en_any)
      noen_reg <= 4'h0;
    else if (noen_reg != 4'hF)
      noen_reg <= noen_reg + 4'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
////////////////////////////////////////
  res_zero_bits_a: assert property (rd_res |=> reg_rdata_o[6:5] == 2'h0 && reg_rdata_o[1:0] == 2'h0)
    else $error("result reserved bits set");
  res_index_range_a: assert property (rd_res |=> reg_rdata_o[4:2] <= IDX_12V)
    else $error("sensor index out of range");
  ctl_fixed_bits_a: assert property (reg_rd_i && reg_addr_i == ADDR_CONTROL |=>
    reg_rdata_o == {5'h00, $past(ctl_reg[10:5]), CTL_LOWRATE_VAL})
    else $error("control readback wrong");
  rate_top_zero_a: assert property (reg_rd_i && reg_addr_i == ADDR_RATE |=> reg_rdata_o[15:2] == 14'h0)
    else $error("rate upper bits set");
  att_needs_en_a: assert property (attention_o |-> $past(att_ok))
    else $error("attention without enables");
  att_with_event_a: assert property (attention_o |-> function_event_o)
    else $error("attention without event");
  event_gives_att_a: assert property (function_event_o && $past(att_ok) |-> attention_o)
    else $error("enabled event without attention");
  status_on_store_a: assert property (function_event_o && !reg_rd_i && !$past(reg_rd_i) |=> voltage_status_flag_o)
    else $error("status not set by store");
  read_clears_a: assert property (rd_res |-> ##3 !voltage_overrun_flag_o &&
    (!voltage_status_flag_o || function_event_o || $past(function_event_o) || $past(function_event_o, 2)))
    else $error("flags not cleared by read");
  idle_no_store_a: assert property (noen_reg == 4'hF |-> !function_event_o)
    else $error("store with no sensor enabled");
  att_seen_c: cover property (attention_o);
  overrun_seen_c: cover property (voltage_overrun_flag_o);
  res_read_c: cover property (rd_res ##1 reg_rdata_o != 16'h0000);
endmodule // vmr_regs_asserts

bind vmr_regs vmr_regs_asserts #(.TEMP_CYC(TEMP_CYC), .VOLT_CYC(VOLT_CYC), .MS_CYC(MS_CYC)) u_vmr_regs_asserts (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .voltage_status_flag_o(voltage_status_flag_o), .voltage_overrun_flag_o(voltage_overrun_flag_o),
  .function_event_o(function_event_o), .attention_o(attention_o)
);

//--- testbench/vmr_host_model.sv
// Purpose : Bus master that reads and writes the registers
// Assumes : Strobes change on the falling edge
// Notes   : Released lines show inverted values
`timescale 1ns/1ps
module vmr_host_model
(
  input  wire logic        mclk_i,
  input  wire logic [15:0] rdata_i,
  output logic             rd_o,
  output logic             wr_o,
  output logic [5:0]       addr_o,
  output logic [15:0]      wdata_o
);
  logic [15:0] rd_data;
  // Idle bus at time zero
  initial
  begin
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    addr_o  = 6'h00;
    wdata_o = 16'h0000;
  end
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge mclk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask
  task automatic read(input logic [5:0] a);
    @(negedge mclk_i);
    addr_o  = a;
    rd_o    = 1'b1;
    @(negedge mclk_i);
    rd_o    = 1'b0;
    addr_o  = ~a;
    rd_data = rdata_i;
  endtask
endmodule // vmr_host_model

//--- testbench/vmr_regs_tb.sv
// Purpose : Self-checking bench for the voltage register block
// Assumes : Shortened phase and tick counts
// Notes   : Host model issues every bus access
`timescale 1ns/1ps
module vmr_regs_tb
  import vmr_pkg::*;
;
  localparam int unsigned MC = 5;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        low_power_select_i = 1'b0;
  logic [49:0] raw_i = {10'h2A5, 10'h000, 10'h15D, 10'h0AB, 10'h180};
  logic [8:0]  code_tab [5] = '{9'h180, 9'h0AB, 9'h15D, 9'h000, 9'h1FF};
  logic        rd, wr, rv, st, ov, fe, at, bz;
  logic [5:0]  ad;
  logic [15:0] wd, rdat;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;
////////////////////////////////////////
  vmr_host_model u_vmr_host_model (.mclk_i(mclk_i), .rdata_i(rdat), .rd_o(rd), .wr_o(wr), .addr_o(ad), .wdata_o(wd));
  vmr_regs #(.TEMP_CYC(20), .VOLT_CYC(10), .MS_CYC(MC)) u_vmr_regs (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(ad), .reg_wdata_i(wd),
    .low_power_select_i(low_power_select_i), .raw_i(raw_i), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .voltage_status_flag_o(st), .voltage_overrun_flag_o(ov), .function_event_o(fe), .attention_o(at),
    .conv_busy_o(bz));
  // Clock and hang guard
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_errors++;
      finish_test();
    end
  end
////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    u_vmr_host_model.read(a);
    chk(u_vmr_host_model.rd_data, exp);
    chk({15'h0, rv}, 16'h0001);
  endtask
  function automatic logic [15:0] res(input int i);
    return {code_tab[i], 2'h0, 3'(i), 2'h0};
  endfunction
  task automatic wait_ev(input logic exp_att);
    int n;
    for (n = 0; n < 9000 && fe !== 1'b1; n++)
      @(negedge mclk_i);
    chk({15'h0, at}, {15'h0, exp_att});
    chk({14'h0, fe, bz}, 16'h0003);
    @(negedge mclk_i);
  endtask
////////////////////////////////////////
  task automatic t_reset();
    rd_chk(ADDR_CONTROL, CTL_RESET);
    rd_chk(ADDR_RATE, 16'h0002);
    rd_chk(ADDR_RESULT, 16'h0000);
    rd_chk(6'h3F, 16'h0000);
    chk({12'h0, st, ov, fe, at}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_access();
    u_vmr_host_model.write(ADDR_CONTROL, 16'hFFFF);
    rd_chk(ADDR_CONTROL, 16'h07FF);
    u_vmr_host_model.write(ADDR_RATE, 16'hFFFF);
    rd_chk(ADDR_RATE, 16'h0003);
    u_vmr_host_model.write(ADDR_RESULT, 16'hFFFF);
    u_vmr_host_model.write(6'h3F, 16'hFFFF);
    rd_chk(ADDR_RESULT, 16'h0000);
    u_vmr_host_model.write(ADDR_CONTROL, 16'h0000);
    rd_chk(ADDR_CONTROL, CTL_RESET);
    $display("test access done");
  endtask
  task automatic t_scan();
    u_vmr_host_model.write(ADDR_RATE, 16'h0000);
    u_vmr_host_model.write(ADDR_CONTROL, 16'h07E0);
    for (int k = 0; k < 6; k++)
    begin
      wait_ev(1'b1);
      chk({15'h0, st}, 16'h0001);
      rd_chk(ADDR_RESULT, res(k % 5));
      repeat (3) @(negedge mclk_i);
      chk({15'h0, st}, 16'h0000);
    end
    wait_ev(1'b1);
    wait_ev(1'b1);
    chk({15'h0, ov}, 16'h0001);
    u_vmr_host_model.read(ADDR_RESULT);
    repeat (3) @(negedge mclk_i);
    chk({15'h0, ov}, 16'h0000);
    $display("test scan done");
  endtask
  task automatic t_skip();
    int p;
    u_vmr_host_model.write(ADDR_CONTROL, 16'h0540);
    wait_ev(1'b0);
    u_vmr_host_model.read(ADDR_RESULT);
    p = u_vmr_host_model.rd_data[4:2];
    chk(16'(p % 2), 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      p = (p == 4) ? 0 : p + 2;
      wait_ev(1'b0);
      rd_chk(ADDR_RESULT, res(p));
    end
    u_vmr_host_model.write(ADDR_CONTROL, 16'h0020);
    repeat (60) @(negedge mclk_i);
    for (int k = 0; k < 200; k++)
    begin
      @(negedge mclk_i);
      chk({13'h0, rv, fe, bz}, 16'h0000);
    end
    $display("test skip done");
  endtask
  task automatic t_rerst();
    u_vmr_host_model.write(ADDR_CONTROL, 16'hFFFF);
    u_vmr_host_model.write(ADDR_RATE, 16'h0001);
    repeat (40) @(negedge mclk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rstn_i = 1'b1;
    rd_chk(ADDR_CONTROL, CTL_RESET);
    rd_chk(ADDR_RATE, 16'h0002);
    rd_chk(ADDR_RESULT, 16'h0000);
    chk({12'h0, st, ov, fe, at}, 16'h0000);
    $display("test rerst done");
  endtask
  task automatic t_period(input logic [1:0] sel, input logic lp, input int ms);
    int n;
    low_power_select_i = lp;
    u_vmr_host_model.write(ADDR_RATE, {14'h0, sel});
    u_vmr_host_model.write(ADDR_CONTROL, 16'h0060);
    wait_ev(1'b1);
    wait_ev(1'b1);
    for (n = 1; n < 9000 && fe !== 1'b1; n++)
      @(negedge mclk_i);
    chk(16'((n > ms * MC - MC && n < ms * MC + MC) ? ms * MC : n), 16'(ms * MC));
    $display("test period %0d done", ms);
  endtask
////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(negedge mclk_i);
    rstn_i = 1'b1;
    t_reset();
    t_access();
    t_scan();
    t_skip();
    t_rerst();
    t_period(2'h1, 1'b0, 91);
    t_period(2'h0, 1'b1, 91);
    t_period(2'h2, 1'b0, 182);
    t_period(2'h1, 1'b1, 364);
    t_period(2'h3, 1'b0, 364);
    t_period(2'h2, 1'b1, 728);
    t_period(2'h3, 1'b1, 1456);
    finish_test();
  end
endmodule // vmr_regs_tb
